// File: shared/egf_pkg.sv
// Package: parameter map, field positions, reset values and rates of the gear follower
package egf_pkg;
  // ****************************************************************
  // Parameter addressing (index:subindex)
  // ****************************************************************
  localparam logic [7:0] EGF_IDX_GEAR = 8'h26;          // Index 38
  localparam logic [7:0] EGF_SIDX_START = 8'h01;
  localparam logic [7:0] EGF_SIDX_ACK = 8'h02;
  localparam logic [7:0] EGF_SIDX_SPEED = 8'h05;
  localparam logic [7:0] EGF_SIDX_NUM = 8'h07;
  localparam logic [7:0] EGF_SIDX_DEN = 8'h08;
  localparam logic [7:0] EGF_SIDX_DIR = 8'h0D;
  // ****************************************************************
  // Reset values and legal ranges
  // ****************************************************************
  localparam logic [31:0] EGF_NUM_RST = 32'h0000_0001;
  localparam logic [31:0] EGF_DEN_RST = 32'h0000_0001;
  localparam logic [31:0] EGF_SPEED_RST = 32'h0000_0BB8;  // 3000 rpm
  localparam logic [31:0] EGF_SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] EGF_SPEED_MAX = 32'h0000_2EE0;  // 12000 rpm
  localparam logic [15:0] EGF_DIR_RST = 16'h0003;
  localparam logic [15:0] EGF_DIR_POS = 16'h0001;
  localparam logic [15:0] EGF_DIR_NEG = 16'h0002;
  localparam logic [15:0] EGF_DIR_BOTH = 16'h0003;
  localparam int EGF_DIR_POS_BIT = 0;
  localparam int EGF_DIR_NEG_BIT = 1;
  // ****************************************************************
  // Mode start codes and acknowledgement bits
  // ****************************************************************
  localparam logic [15:0] EGF_START_OFF = 16'h0000;
  localparam logic [15:0] EGF_START_IMM = 16'h0001;
  localparam logic [15:0] EGF_START_COMP = 16'h0002;
  localparam int EGF_ACK_SYNC_BIT = 13;
  localparam int EGF_ACK_END_BIT = 14;
  localparam int EGF_ACK_ERR_BIT = 15;
  // ****************************************************************
  // Rates
  // ****************************************************************
  localparam logic [32:0] EGF_CLK_HZ = 33'd40_000_000;
  localparam logic [32:0] EGF_SEC_PER_MIN = 33'd60;
  localparam logic [32:0] EGF_STEP_PERIOD = 33'(EGF_CLK_HZ * EGF_SEC_PER_MIN);
  localparam int EGF_PULSES_PER_REV = 16384;
  typedef enum logic [1:0] {EGF_IDLE, EGF_FOLLOW, EGF_COMP} egf_mode_t;
endpackage : egf_pkg

// File: hdl/egf_follower.sv
// Electronic gear follower: ratio scaling, speed cap, direction gate, resync
`timescale 1ns/100ps
// Behaviour
// R1: Output pulses are reference pulses times num/den
// R2: Negative numerator reverses motor direction
// R3: Ratio resets to one to one
// R4: Ratio changes take effect on numerator write
// R5: Numerator is full signed 32-bit
// R6: Denominator accepted only from one upward
// R7: No ramp; acceleration left to current limit
// R8: Speed capped by ceiling, default 3000 rpm
// R9: Excess deviation at activation flags contouring error
// R10: Direction code suppresses forbidden motion
// R11: Stop write, other mode, quick stop uncouple
// R12: Pulses kept only while amplifier on
// R13: Start code 2 enters compensating mode
// R14: Compensation runs at full permitted speed
// R15: Compensation targets uninterrupted position
// R16: Added position only updates while active
// R17: Compensation respects enabled direction
// R18: Code 0 off, 1 immediate sync
// R19: Ack word bits 13, 14, 15
// R20: Division remainder carried between updates
module egf_follower #(
  parameter int PULSES_PER_REV = egf_pkg::EGF_PULSES_PER_REV
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic par_wr_in,
  input wire logic par_rd_in,
  input wire logic [7:0] par_index_in,
  input wire logic [7:0] par_subindex_in,
  input wire logic [31:0] par_wdata_in,
  output logic [31:0] par_rdata_out,
  output logic par_ack_out,
  output logic par_err_out,
  input wire logic ref_pulse_in,
  input wire logic ref_dir_in,
  input wire logic amp_on_in,
  input wire logic quick_stop_in,
  input wire logic other_mode_in,
  input wire logic [31:0] following_error_threshold_in,
  output logic motor_step_out,
  output logic motor_dir_out,
  output logic [31:0] setpoint_pos_out,
  output logic [31:0] gear_added_position_out,
  output logic [31:0] input_pulse_position_out,
  output logic [15:0] follow_mode_ack_out,
  output logic contouring_error_out
);
  import egf_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  egf_mode_t mode_r;
  logic [31:0] num_r, den_r, den_pend_r, speed_r;
  logic [15:0] dir_r, start_r;
  logic signed [63:0] resid_r;
  logic signed [31:0] target_r, setp_r;
  logic [32:0] phase_r;
  logic err_r;
  logic [31:0] added_r, refpos_r;

  // Decode of a parameter access by subindex
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] sidx, input logic [7:0] want);
    return (idx == EGF_IDX_GEAR) && (sidx == want);
  endfunction

  logic wr_start, wr_num, wr_den, wr_speed, wr_dir, rd_any, known;
  assign wr_start = par_wr_in && hit(par_index_in, par_subindex_in, EGF_SIDX_START);
  assign wr_num = par_wr_in && hit(par_index_in, par_subindex_in, EGF_SIDX_NUM);
  assign wr_den = par_wr_in && hit(par_index_in, par_subindex_in, EGF_SIDX_DEN);
  assign wr_speed = par_wr_in && hit(par_index_in, par_subindex_in, EGF_SIDX_SPEED);
  assign wr_dir = par_wr_in && hit(par_index_in, par_subindex_in, EGF_SIDX_DIR);
  assign known = hit(par_index_in, par_subindex_in, EGF_SIDX_START) || hit(par_index_in, par_subindex_in, EGF_SIDX_ACK)
    || hit(par_index_in, par_subindex_in, EGF_SIDX_SPEED) || hit(par_index_in, par_subindex_in, EGF_SIDX_NUM)
    || hit(par_index_in, par_subindex_in, EGF_SIDX_DEN) || hit(par_index_in, par_subindex_in, EGF_SIDX_DIR);
  assign rd_any = par_rd_in && !par_wr_in;

  // ****************************************************************
  // Activation decision
  // ****************************************************************
  logic uncouple, start_imm, start_comp;
  logic signed [31:0] dev;
  logic [31:0] dev_abs;
  assign uncouple = (wr_start && par_wdata_in[15:0] == EGF_START_OFF) || other_mode_in || quick_stop_in; // R11
  assign start_imm = wr_start && par_wdata_in[15:0] == EGF_START_IMM && amp_on_in; // R18
  assign start_comp = wr_start && par_wdata_in[15:0] == EGF_START_COMP && amp_on_in; // R13
  assign dev = target_r - setp_r;
  assign dev_abs = dev[31] ? 32'(-dev) : 32'(dev);
  // Error too large to catch up safely: refuse and flag instead
  logic comp_fail;
  assign comp_fail = start_comp && (dev_abs > following_error_threshold_in); // R9

  // Mode sequencing; uncoupling wins over a simultaneous start
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_r <= EGF_IDLE;
      err_r <= 1'b0;
    end else if (ce_in) begin
      if (uncouple || !amp_on_in) begin
        mode_r <= EGF_IDLE; // R11
      end else if (start_imm) begin
        mode_r <= EGF_FOLLOW; // R18
        err_r <= 1'b0;
      end else if (comp_fail) begin
        mode_r <= EGF_IDLE;
        err_r <= 1'b1; // R9
      end else if (start_comp) begin
        mode_r <= EGF_COMP; // R13
        err_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Parameter registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      num_r <= EGF_NUM_RST; // R3
      den_r <= EGF_DEN_RST; // R3
      den_pend_r <= EGF_DEN_RST;
      speed_r <= EGF_SPEED_RST; // R8
      dir_r <= EGF_DIR_RST; // R10
      start_r <= EGF_START_OFF;
    end else if (ce_in) begin
      // Full signed range; the staged denominator goes live with it
      if (wr_num) begin
        num_r <= par_wdata_in; // R5
        den_r <= den_pend_r; // R4
      end
      // Zero or negative would break the divider, so it is dropped
      if (wr_den && !par_wdata_in[31] && par_wdata_in != '0) begin
        den_pend_r <= par_wdata_in; // R6
      end
      if (wr_speed && par_wdata_in >= EGF_SPEED_MIN && par_wdata_in <= EGF_SPEED_MAX) begin
        speed_r <= par_wdata_in; // R8
      end
      if (wr_dir && (par_wdata_in[15:0] == EGF_DIR_POS || par_wdata_in[15:0] == EGF_DIR_NEG
          || par_wdata_in[15:0] == EGF_DIR_BOTH)) begin
        dir_r <= par_wdata_in[15:0]; // R10
      end
      if (wr_start) begin
        start_r <= par_wdata_in[15:0];
      end
    end
  end

  // Read data and access answer, one cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_rdata_out <= '0;
      par_ack_out <= 1'b0;
      par_err_out <= 1'b0;
    end else if (ce_in) begin
      par_ack_out <= par_wr_in || par_rd_in;
      par_err_out <= (par_wr_in || par_rd_in) && !known;
      if (rd_any) begin
        unique case (par_subindex_in)
          EGF_SIDX_START: par_rdata_out <= {16'h0000, start_r};
          EGF_SIDX_ACK: par_rdata_out <= {16'h0000, follow_mode_ack_out};
          EGF_SIDX_SPEED: par_rdata_out <= speed_r;
          EGF_SIDX_NUM: par_rdata_out <= num_r;
          EGF_SIDX_DEN: par_rdata_out <= den_pend_r;
          EGF_SIDX_DIR: par_rdata_out <= {16'h0000, dir_r};
          default: par_rdata_out <= '0;
        endcase
        if (par_index_in != EGF_IDX_GEAR) begin
          par_rdata_out <= '0;
        end
      end
    end
  end

  // ****************************************************************
  // Ratio scaling with carried remainder
  // ****************************************************************
  logic signed [63:0] num_s, den_s, resid_add;
  assign num_s = 64'(signed'(num_r));
  assign den_s = 64'(signed'({1'b0, den_r[30:0]}));
  // Reverse pulses subtract; a negative ratio flips the sign again
  assign resid_add = ref_pulse_in ? (ref_dir_in ? -num_s : num_s) : 64'sh0; // R1 R2

  // Pulses owed keep accruing even uncoupled, so resync can land exactly
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      resid_r <= '0;
      target_r <= '0;
    end else if (ce_in) begin
      if (!amp_on_in) begin
        resid_r <= '0; // R12
        target_r <= setp_r; // R12
      end else if (start_imm) begin
        resid_r <= '0; // R18
        target_r <= setp_r; // R18
      end else if (resid_r + resid_add >= den_s) begin
        resid_r <= resid_r + resid_add - den_s; // R20
        target_r <= target_r + 32'sh1; // R15
      end else if (resid_r + resid_add <= -den_s) begin
        resid_r <= resid_r + resid_add + den_s; // R20
        target_r <= target_r - 32'sh1; // R15
      end else begin
        resid_r <= resid_r + resid_add; // R20
      end
    end
  end

  // Raw input position keeps counting in every mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refpos_r <= '0;
    end else if (ce_in && ref_pulse_in) begin
      refpos_r <= ref_dir_in ? refpos_r - 32'h1 : refpos_r + 32'h1; // R16
    end
  end

  // ****************************************************************
  // Speed cap and stepping
  // ****************************************************************
  // Phase accumulator: one step slot per period at speed_r rpm.
  // No ramp term: the current loop outside bounds acceleration.
  logic [32:0] rate, phase_sum;
  logic slot, want_pos, want_neg, step;
  assign rate = 33'(speed_r * 32'(PULSES_PER_REV));
  assign phase_sum = phase_r + rate;
  assign slot = phase_sum >= EGF_STEP_PERIOD; // R8 R14
  assign want_pos = dev > 32'sh0 && dir_r[EGF_DIR_POS_BIT]; // R10 R17
  assign want_neg = dev < 32'sh0 && dir_r[EGF_DIR_NEG_BIT]; // R10 R17
  assign step = (mode_r != EGF_IDLE) && slot && (want_pos || want_neg) && !uncouple; // R7 R14

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= '0;
    end else if (ce_in) begin
      phase_r <= slot ? phase_sum - EGF_STEP_PERIOD : phase_sum; // R8
    end
  end

  // Setpoint and step outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      setp_r <= '0;
      motor_step_out <= 1'b0;
      motor_dir_out <= 1'b0;
    end else if (ce_in) begin
      motor_step_out <= step;
      if (step) begin
        motor_dir_out <= want_neg;
        setp_r <= want_neg ? setp_r - 32'sh1 : setp_r + 32'sh1; // R14
      end
    end
  end

  // Added position frozen outside gear mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      added_r <= '0;
    end else if (ce_in && step) begin
      added_r <= want_neg ? added_r - 32'h1 : added_r + 32'h1; // R16
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  logic [15:0] ack;
  always_comb begin
    ack = '0;
    ack[EGF_ACK_SYNC_BIT] = (mode_r != EGF_IDLE) && (dev == 32'sh0); // R19
    ack[EGF_ACK_END_BIT] = (mode_r == EGF_IDLE) && !motor_step_out; // R19
    ack[EGF_ACK_ERR_BIT] = err_r; // R19
  end
  assign follow_mode_ack_out = ack;
  assign contouring_error_out = err_r;
  assign setpoint_pos_out = setp_r;
  assign gear_added_position_out = added_r;
  assign input_pulse_position_out = refpos_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  ratio_on_num_a: assert property (ce_in && wr_num |=> den_r == $past(den_pend_r)) // R4
    else $error("ratio not taken on numerator write");
  den_hold_a: assert property (ce_in && !wr_num |=> den_r == $past(den_r)) // R4
    else $error("denominator changed without numerator write");
  den_range_a: assert property (den_pend_r != '0 && !den_pend_r[31]) // R6
    else $error("denominator out of range");
  dir_block_a: assert property (motor_step_out && motor_dir_out |-> $past(dir_r[EGF_DIR_NEG_BIT])) // R10
    else $error("negative step while forbidden");
  dir_pos_a: assert property (motor_step_out && !motor_dir_out |-> $past(dir_r[EGF_DIR_POS_BIT])) // R17
    else $error("positive step while forbidden");
  uncouple_a: assert property (ce_in && uncouple |=> mode_r == EGF_IDLE) // R11
    else $error("gear still coupled after uncouple");
  amp_off_a: assert property (ce_in && !amp_on_in |=> resid_r == 64'sh0 && target_r == $past(setp_r)) // R12
    else $error("pulses kept with amplifier off");
  comp_err_a: assert property (ce_in && comp_fail && !uncouple |=> err_r && mode_r == EGF_IDLE) // R9
    else $error("contouring error not flagged");
  comp_start_a: assert property (ce_in && start_comp && !comp_fail && !uncouple |=> mode_r == EGF_COMP) // R13
    else $error("compensating mode not entered");
  added_idle_a: assert property (ce_in && mode_r == EGF_IDLE |=> $stable(added_r)) // R16
    else $error("added position moved while idle");
  // An in-range remainder with no pulse must be carried, never dropped
  logic resid_idle;
  assign resid_idle = amp_on_in && !start_imm && !ref_pulse_in && resid_r < den_s && resid_r > -den_s;
  resid_keep_a: assert property (ce_in && resid_idle |=> $stable(resid_r)) // R20
    else $error("remainder not carried");
  step_idle_a: assert property (ce_in && mode_r == EGF_IDLE |=> !motor_step_out) // R18
    else $error("step while deactivated");

  imm_c: cover property (ce_in && start_imm ##[1:50] motor_step_out);
  comp_c: cover property (mode_r == EGF_COMP ##[1:200] ack[EGF_ACK_SYNC_BIT]);
  err_c: cover property (ce_in && comp_fail);
  amp_c: cover property (mode_r != EGF_IDLE ##1 !amp_on_in);
endmodule // egf_follower

// File: verif/egf_pulse_src.sv
// Partner model: reference pulse source with prompt or slow pacing
`timescale 1ns/100ps
module egf_pulse_src (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] count_in,
  input wire logic dir_in,
  input wire logic [3:0] gap_in,
  output logic pulse_out,
  output logic dir_out,
  output logic busy_out
);
  int left = 0;
  int wait_c = 0;
  initial begin
    pulse_out = 1'b0;
    dir_out = 1'b0;
    busy_out = 1'b0;
  end
  // ****************************************************************
  // Pulse pacing
  // ****************************************************************
  // Direction wanders between pulses, since only its value beside a pulse counts
  always @(posedge clk_in) begin
    pulse_out <= 1'b0;
    dir_out <= ~dir_out;
    if (go_in) begin
      left = count_in;
      wait_c = 0;
      busy_out <= 1'b1;
    end else if (left > 0 && wait_c > 0) begin
      wait_c--;
    end else if (left > 0) begin
      pulse_out <= 1'b1;
      dir_out <= dir_in;
      left--;
      wait_c = gap_in;
    end else begin
      busy_out <= 1'b0;
    end
  end
endmodule // egf_pulse_src

// File: verif/tb_top.sv
// Testbench: gear follower fed by the pulse source model, random and corner cases
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import egf_pkg::*;
  logic clk_in = 1'b0, rst_n_in = 1'b0, par_wr = 1'b0, par_rd = 1'b0, amp = 1'b1, qstop = 1'b0, other = 1'b0;
  logic go = 1'b0, pdir = 1'b0, ce = 1'b1, ack, err, ref_p, ref_d, step, mdir, cerr, busy, d, ev;
  logic [7:0] pidx = EGF_IDX_GEAR, aidx = EGF_IDX_GEAR, sidx = 8'h00, cnt = 8'h00;
  logic [3:0] gap = 4'h0;
  logic [31:0] wdata = 32'h0, thr = 32'hFFFF, rdata, spos, addpos, inpos, rv;
  logic [15:0] ackw;
  int mismatches = 0, checks = 0, seed = 32'h9FEFA9BB, k, n, base, ab, ib, ex, steps, sp;
  int tn[5] = '{2, -3, 5, 1, 1};
  int td[5] = '{4, 2, 3, 7, 1};
  int ln = 1, ld = 1;
  longint lim;
  always #12.5 clk_in = ~clk_in;
  egf_follower uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .par_wr_in(par_wr), .par_rd_in(par_rd),
    .par_index_in(pidx), .par_subindex_in(sidx), .par_wdata_in(wdata), .par_rdata_out(rdata), .par_ack_out(ack),
    .par_err_out(err), .ref_pulse_in(ref_p), .ref_dir_in(ref_d), .amp_on_in(amp), .quick_stop_in(qstop),
    .other_mode_in(other), .following_error_threshold_in(thr), .motor_step_out(step), .motor_dir_out(mdir),
    .setpoint_pos_out(spos), .gear_added_position_out(addpos), .input_pulse_position_out(inpos),
    .follow_mode_ack_out(ackw), .contouring_error_out(cerr));
  egf_pulse_src src (.clk_in(clk_in), .go_in(go), .count_in(cnt), .dir_in(pdir), .gap_in(gap),
    .pulse_out(ref_p), .dir_out(ref_d), .busy_out(busy));
  // ****************************************************************
  // Bench tasks
  // ****************************************************************
  task close_out;
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Expected setpoint move for a burst; truncates toward zero like the carried remainder
  function automatic int gear_move(input int np, input logic dp, input int nu, input int de);
    return ((dp ? -np : np) * nu) / de;
  endfunction
  // One parameter access; strobe held for exactly the taking edge
  task acc(input logic w, input logic [7:0] s, input logic [31:0] dv);
    @(posedge clk_in);
    par_wr <= w;
    par_rd <= ~w;
    pidx <= aidx;
    sidx <= s;
    wdata <= dv;
    @(posedge clk_in);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    #1;
    `CHK("par_ack", 1'b1, ack)
    rv = rdata;
    ev = err;
  endtask
  task rd_chk(input logic [7:0] s, input logic [31:0] e);
    acc(1'b0, s, 32'h0);
    `CHK("par_read", e, rv)
  endtask
  task pulses(input int np, input logic dp, input logic [3:0] gp);
    int i;
    @(posedge clk_in);
    go <= 1'b1;
    cnt <= np[7:0];
    pdir <= dp;
    gap <= gp;
    @(posedge clk_in);
    go <= 1'b0;
    // Busy is launched on this same edge, so look only once it has settled
    #1;
    for (i = 0; busy !== 1'b0; i++) begin
      @(posedge clk_in);
      #1;
      if (i > 3000) begin
        mismatches++;
        close_out();
      end
    end
  endtask
  // Bounded wait for the setpoint to reach a target
  task settle(input int e);
    int i;
    for (i = 0; spos !== 32'(e); i++) begin
      @(posedge clk_in);
      #1;
      if (i > 8000) begin
        mismatches++;
        close_out();
      end
    end
  endtask
  task idle(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    idle(4);
    `CHK("ack_rst", 16'h4000, ackw)
    rst_n_in <= 1'b1;
    rd_chk(EGF_SIDX_NUM, 32'h1);
    rd_chk(EGF_SIDX_DEN, 32'h1);
    rd_chk(EGF_SIDX_SPEED, 32'hBB8);
    rd_chk(EGF_SIDX_DIR, 32'h3);
    rd_chk(EGF_SIDX_START, 32'h0);
    rd_chk(EGF_SIDX_ACK, 32'h4000);
    // Out-of-range writes must leave the stored value alone
    acc(1'b1, EGF_SIDX_DEN, 32'h0);
    acc(1'b1, EGF_SIDX_DEN, 32'h8000_0000);
    rd_chk(EGF_SIDX_DEN, 32'h1);
    acc(1'b1, EGF_SIDX_DIR, 32'h4);
    rd_chk(EGF_SIDX_DIR, 32'h3);
    acc(1'b1, EGF_SIDX_NUM, 32'h8000_0000);
    rd_chk(EGF_SIDX_NUM, 32'h8000_0000);
    aidx = 8'h27;
    acc(1'b0, EGF_SIDX_NUM, 32'h0);
    `CHK("par_err", 1'b1, ev)
    aidx = EGF_IDX_GEAR;
    acc(1'b1, EGF_SIDX_NUM, 32'h1);
    // Step rate under a long backlog, both ceilings
    for (k = 0; k < 2; k++) begin
      sp = k ? EGF_SPEED_MAX : EGF_SPEED_RST;
      acc(1'b1, EGF_SIDX_SPEED, 32'(sp));
      acc(1'b1, EGF_SIDX_START, 32'(EGF_START_IMM));
      base = spos;
      pulses(100, 1'b0, 4'h0);
      steps = 0;
      for (n = 0; n < 1000; n++) begin
        idle(1);
        steps += step;
      end
      lim = (longint'(1000) * sp * EGF_PULSES_PER_REV) / longint'(EGF_STEP_PERIOD);
      `CHK("step_rate", 1'b1, (steps >= lim - 1 && steps <= lim + 1))
      settle(base + 100);
    end
    // Ratio table; one entry stages the denominator alone
    for (k = 0; k < 5; k++) begin
      acc(1'b1, EGF_SIDX_DEN, 32'(td[k]));
      if (k != 3) begin
        acc(1'b1, EGF_SIDX_NUM, 32'(tn[k]));
        ln = tn[k];
        ld = td[k];
      end
      acc(1'b1, EGF_SIDX_START, 32'(EGF_START_IMM));
      base = spos;
      n = ($random(seed) & 32'h1F) + 1;
      d = 1'($random(seed));
      pulses(n, d, 4'($random(seed) & 3));
      ex = base + gear_move(n, d, ln, ld);
      settle(ex);
      `CHK("setpoint", 32'(ex), spos)
      if (ex != base) `CHK("motor_dir", (ex < base), mdir)
      `CHK("sync", 1'b1, ackw[EGF_ACK_SYNC_BIT])
    end
    // Forbidden direction holds the motor until enabled
    for (k = 1; k < 3; k++) begin
      acc(1'b1, EGF_SIDX_DIR, 32'(k));
      acc(1'b1, EGF_SIDX_START, 32'(EGF_START_IMM));
      base = spos;
      pulses(4, k == 1, 4'h1);
      idle(300);
      `CHK("dir_block", 32'(base), spos)
      acc(1'b1, EGF_SIDX_DIR, 32'(EGF_DIR_BOTH));
      settle(base + ((k == 1) ? -4 : 4));
    end
    // Uncouple by stop write, quick stop or other mode, then compensate
    for (k = 0; k < 3; k++) begin
      acc(1'b1, EGF_SIDX_START, 32'(EGF_START_IMM));
      base = spos;
      ab = addpos;
      ib = inpos;
      @(posedge clk_in);
      qstop <= (k == 1);
      other <= (k == 2);
      @(posedge clk_in);
      qstop <= 1'b0;
      other <= 1'b0;
      if (k == 0) acc(1'b1, EGF_SIDX_START, 32'(EGF_START_OFF));
      n = ($random(seed) & 32'h1F) + 1;
      pulses(n, 1'b0, 4'h0);
      idle(50);
      `CHK("uncoupled", 32'(base), spos)
      `CHK("added_hold", 32'(ab), addpos)
      `CHK("input_pos", 32'(ib + n), inpos)
      `CHK("ack_end", 1'b1, ackw[EGF_ACK_END_BIT])
      acc(1'b1, EGF_SIDX_START, 32'(EGF_START_COMP));
      settle(base + n);
      `CHK("caught_up", 32'(base + n), spos)
      `CHK("added_run", 32'(ab + n), addpos)
    end
    // Deviation above threshold at compensating start
    acc(1'b1, EGF_SIDX_START, 32'(EGF_START_OFF));
    base = spos;
    pulses(6, 1'b0, 4'h0);
    @(posedge clk_in);
    thr <= 32'h2;
    acc(1'b1, EGF_SIDX_START, 32'(EGF_START_COMP));
    idle(3);
    `CHK("cont_err", 1'b1, cerr)
    `CHK("ack_err", 1'b1, ackw[EGF_ACK_ERR_BIT])
    `CHK("no_move", 32'(base), spos)
    // Immediate start drops the backlog left above, then amplifier off discards a new one
    acc(1'b1, EGF_SIDX_START, 32'(EGF_START_IMM));
    idle(50);
    `CHK("imm_sync", 32'(base), spos)
    `CHK("err_clear", 1'b0, cerr)
    acc(1'b1, EGF_SIDX_START, 32'(EGF_START_OFF));
    base = spos;
    pulses(6, 1'b0, 4'h0);
    @(posedge clk_in);
    amp <= 1'b0;
    @(posedge clk_in);
    amp <= 1'b1;
    thr <= 32'hFFFF;
    acc(1'b1, EGF_SIDX_START, 32'(EGF_START_COMP));
    idle(200);
    `CHK("discarded", 32'(base), spos)
    // Clock enable low freezes the input count
    ib = inpos;
    @(posedge clk_in);
    ce <= 1'b0;
    pulses(3, 1'b0, 4'h0);
    `CHK("ce_freeze", 32'(ib), inpos)
    ce <= 1'b1;
    // Reset in mid-run restores the one to one ratio
    acc(1'b1, EGF_SIDX_DEN, 32'h5);
    acc(1'b1, EGF_SIDX_NUM, 32'h3);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    idle(4);
    `CHK("ack_rst", 16'h4000, ackw)
    rst_n_in <= 1'b1;
    rd_chk(EGF_SIDX_NUM, 32'h1);
    rd_chk(EGF_SIDX_DEN, 32'h1);
    close_out();
  end
endmodule // tb_top
